// file: nacb_csr_bank.sv
// Module: auxiliary CSR bank with missed counter, EEPROM port and timer
`timescale 1ns/10ps
module nacb_csr_bank
    import nacb_pkg::*;
#(
    parameter int TICK_PERIOD = TICK_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    input  wire logic        frame_dropped,
    input  wire logic        ev_tx_done,
    input  wire logic        ev_tx_stopped,
    input  wire logic        ev_tx_unavail,
    input  wire logic        eeprom_dout,
    output logic             eeprom_clk,
    output logic             eeprom_cs,
    output logic             eeprom_din,
    output logic             eeprom_rd_en,
    output logic             eeprom_wr_en,
    output logic             irq_tx_done,
    output logic             irq_tx_stopped,
    output logic             irq_tx_unavail,
    output logic             irq_timer,
    output logic             timer_expired,
    output logic [15:0]      crc_seed,
    output logic             pattern_one_match_en
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    nacb_bus_s bus;
    assign bus = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};

    // Matches an access strobe to one register
    function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
        hit = strobe && (a == ofs);
    endfunction : hit

    logic wr_ie, wr_ep, wr_tm, wr_wk, rd_mf;
    assign wr_ie = hit(bus.wr, bus.addr, OFS_IRQ_EN);
    assign wr_ep = hit(bus.wr, bus.addr, OFS_EEPROM);
    assign wr_tm = hit(bus.wr, bus.addr, OFS_TIMER);
    assign wr_wk = hit(bus.wr, bus.addr, OFS_WAKEUP);
    assign rd_mf = hit(bus.rd, bus.addr, OFS_MISSED);

    // ------------------------------------------------------------
    // Interrupt enable mask
    // ------------------------------------------------------------
    logic [16:0] ie_q;
    // Software-written enables, reset to zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ie_q <= IRQ_EN_RST;
        end else if (wr_ie) begin
            ie_q <= 17'h00000;
            ie_q[IE_TX_DONE]  <= bus.wdata[IE_TX_DONE];
            ie_q[IE_TX_STOP]  <= bus.wdata[IE_TX_STOP];
            ie_q[IE_TX_UNAV]  <= bus.wdata[IE_TX_UNAV];
            ie_q[IE_TIMER]    <= bus.wdata[IE_TIMER];
            ie_q[IE_ABNORMAL] <= bus.wdata[IE_ABNORMAL];
            ie_q[IE_NORMAL]   <= bus.wdata[IE_NORMAL];
        end
    end

    // ------------------------------------------------------------
    // Missed frame counter
    // ------------------------------------------------------------
    logic [15:0] mf_q;
    logic        ovf_q;
    logic        mf_wrap;
    assign mf_wrap = frame_dropped && (mf_q == 16'hFFFF);
    // Count drops; read clears, a drop in the read cycle counts as one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mf_q <= 16'h0000;
        end else if (rd_mf) begin
            mf_q <= {15'h0000, frame_dropped};
        end else if (frame_dropped) begin
            mf_q <= mf_q + 16'h0001;
        end
    end
    // Sticky overflow, read clear wins over set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else if (mf_wrap && !rd_mf) begin
            ovf_q <= 1'b1;
        end else if (rd_mf) begin
            ovf_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // EEPROM serial port
    // ------------------------------------------------------------
    logic [3:0] ep_q;  // din, clk, cs in low bits; bit 3 unused
    logic       ep_sel_q, ep_rd_q, ep_wr_q, dout_q;
    // Port bits, software toggles the clock bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ep_q     <= EEPROM_RST;
            ep_sel_q <= 1'b0;
            ep_rd_q  <= 1'b0;
            ep_wr_q  <= 1'b0;
        end else if (wr_ep) begin
            ep_q[EP_CS]  <= bus.wdata[EP_CS];
            ep_q[EP_CLK] <= bus.wdata[EP_CLK];
            ep_q[EP_DIN] <= bus.wdata[EP_DIN];
            ep_q[EP_DOUT] <= 1'b1;
            ep_sel_q     <= bus.wdata[EP_SEL];
            ep_rd_q      <= bus.wdata[EP_RD];
            ep_wr_q      <= bus.wdata[EP_WR];
        end
    end
    // Capture EEPROM data line, reads one after reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dout_q <= 1'b1;
        end else begin
            dout_q <= eeprom_dout;
        end
    end
    // Pins follow port bits, read and write enables gated by select
    nacb_eeprom_s ep_d;
    always_comb begin
        ep_d.clk   = ep_q[EP_CLK];
        ep_d.cs    = ep_q[EP_CS];
        ep_d.din   = ep_q[EP_DIN];
        ep_d.rd_en = ep_sel_q && ep_rd_q;
        ep_d.wr_en = ep_sel_q && ep_wr_q;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eeprom_clk   <= 1'b1;
            eeprom_cs    <= 1'b1;
            eeprom_din   <= 1'b1;
            eeprom_rd_en <= 1'b0;
            eeprom_wr_en <= 1'b0;
        end else begin
            eeprom_clk   <= ep_d.clk;
            eeprom_cs    <= ep_d.cs;
            eeprom_din   <= ep_d.din;
            eeprom_rd_en <= ep_d.rd_en;
            eeprom_wr_en <= ep_d.wr_en;
        end
    end

    // ------------------------------------------------------------
    // General-purpose countdown timer
    // ------------------------------------------------------------
    typedef enum logic [0:0] {TM_IDLE, TM_RUN} nacb_tm_e;
    nacb_tm_e    tm_state_q;
    logic [15:0] tm_load_q, tm_cnt_q;
    logic        tm_cont_q, tick;

    nacb_tick #(
        .PERIOD (TICK_PERIOD)
    ) u_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick_q  (tick)
    );

    // Load value and mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tm_load_q <= TIMER_RST[15:0];
            tm_cont_q <= TIMER_RST[TM_CONT];
        end else if (wr_tm) begin
            tm_load_q <= bus.wdata[15:0];
            tm_cont_q <= bus.wdata[TM_CONT];
        end
    end
    // Countdown state machine
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tm_state_q    <= TM_IDLE;
            tm_cnt_q      <= 16'h0000;
            timer_expired <= 1'b0;
        end else begin
            timer_expired <= 1'b0;
            if (wr_tm) begin
                tm_cnt_q   <= bus.wdata[15:0];
                tm_state_q <= (bus.wdata[15:0] != 16'h0000) ? TM_RUN : TM_IDLE;
            end else begin
                case (tm_state_q)
                    TM_IDLE: begin
                        tm_state_q <= TM_IDLE;
                    end
                    TM_RUN: begin
                        if (tick) begin
                            if (tm_cnt_q == 16'h0001) begin
                                timer_expired <= 1'b1;
                                if (tm_cont_q) begin
                                    tm_cnt_q <= tm_load_q;
                                end else begin
                                    tm_cnt_q   <= 16'h0000;
                                    tm_state_q <= TM_IDLE;
                                end
                            end else begin
                                tm_cnt_q <= tm_cnt_q - 16'h0001;
                            end
                        end
                    end
                    default: begin
                        tm_state_q <= TM_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Wake-up control
    // ------------------------------------------------------------
    logic crc_sel_q;
    // Seed select and pattern one enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            crc_sel_q            <= WAKEUP_RST[1];
            pattern_one_match_en <= WAKEUP_RST[0];
        end else if (wr_wk) begin
            crc_sel_q            <= bus.wdata[WK_CRC];
            pattern_one_match_en <= bus.wdata[WK_PAT1];
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            crc_seed <= CRC_SEED_0;
        end else begin
            crc_seed <= crc_sel_q ? CRC_SEED_1 : CRC_SEED_0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------
    // Per-source enable ANDed with its summary enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_tx_done    <= 1'b0;
            irq_tx_stopped <= 1'b0;
            irq_tx_unavail <= 1'b0;
            irq_timer      <= 1'b0;
        end else begin
            irq_tx_unavail <= ev_tx_unavail && ie_q[IE_TX_UNAV] && ie_q[IE_NORMAL];
            irq_tx_stopped <= ev_tx_stopped && ie_q[IE_TX_STOP] && ie_q[IE_ABNORMAL];
            irq_tx_done    <= ev_tx_done && ie_q[IE_TX_DONE] && ie_q[IE_NORMAL];
            irq_timer      <= timer_expired && ie_q[IE_TIMER] && ie_q[IE_ABNORMAL];
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h00000000;
        case (bus.addr)
            OFS_IRQ_EN: rd_d = {15'h0000, ie_q};
            OFS_MISSED: rd_d = {15'h0000, ovf_q, mf_q};
            OFS_EEPROM: begin
                rd_d[EP_RD]   = ep_rd_q;
                rd_d[EP_WR]   = ep_wr_q;
                rd_d[EP_SEL]  = ep_sel_q;
                rd_d[EP_DOUT] = dout_q;
                rd_d[EP_DIN]  = ep_q[EP_DIN];
                rd_d[EP_CLK]  = ep_q[EP_CLK];
                rd_d[EP_CS]   = ep_q[EP_CS];
            end
            OFS_TIMER:  rd_d = {15'h0000, tm_cont_q, tm_cnt_q};
            OFS_WAKEUP: begin
                rd_d[WK_CRC]  = crc_sel_q;
                rd_d[WK_PAT1] = pattern_one_match_en;
            end
            default:    rd_d = 32'h00000000;
        endcase
    end
    // Data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_rdata <= 32'h00000000;
        end else begin
            bus_rdata <= bus.rd ? rd_d : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    tx_unav_gate_a: assert property (irq_tx_unavail |-> $past(ie_q[IE_TX_UNAV] && ie_q[IE_NORMAL]))
        else $error("tx unavail irq without enables");
    tx_stop_gate_a: assert property (irq_tx_stopped |-> $past(ie_q[IE_TX_STOP] && ie_q[IE_ABNORMAL]))
        else $error("tx stopped irq without enables");
    tx_done_gate_a: assert property ($past(ev_tx_done && ie_q[IE_TX_DONE] && ie_q[IE_NORMAL]) |-> irq_tx_done)
        else $error("tx done irq missing");
    missed_inc_a: assert property (frame_dropped && !rd_mf && mf_q != 16'hFFFF |=> mf_q == $past(mf_q) + 16'h0001)
        else $error("missed counter did not increment");
    missed_clear_a: assert property (rd_mf && !frame_dropped |=> mf_q == 16'h0000 && !ovf_q)
        else $error("missed counter not cleared by read");
    ovf_set_a: assert property (mf_wrap && !rd_mf |=> ovf_q && mf_q == 16'h0000)
        else $error("overflow flag not set");
    ee_rd_gate_a: assert property (eeprom_rd_en |-> $past(ep_sel_q && ep_rd_q))
        else $error("eeprom read without select");
    ee_wr_gate_a: assert property (eeprom_wr_en |-> $past(ep_sel_q && ep_wr_q))
        else $error("eeprom write without select");
    ee_pins_a: assert property (wr_ep |=> ##1 eeprom_cs == $past(bus.wdata[EP_CS], 2))
        else $error("chip select pin not following port");
    tm_reload_a: assert property (timer_expired && tm_cont_q |-> tm_cnt_q == tm_load_q)
        else $error("continuous timer did not reload");
    tm_stop_a: assert property (timer_expired && !tm_cont_q && !$past(wr_tm) |-> tm_state_q == TM_IDLE)
        else $error("single shot timer did not stop");
    tm_irq_a: assert property (irq_timer |-> $past(timer_expired && ie_q[IE_TIMER] && ie_q[IE_ABNORMAL]))
        else $error("timer irq without enables");
    tm_dec_a: assert property (tick && !wr_tm && tm_state_q == TM_RUN && tm_cnt_q > 16'h0001
        |=> tm_cnt_q == $past(tm_cnt_q) - 16'h0001)
        else $error("timer did not decrement on tick");
    ee_din_pin_a: assert property (wr_ep |-> ##2 eeprom_din == $past(bus.wdata[EP_DIN], 2))
        else $error("data pin not following port");
    ee_dout_cap_a: assert property (1'b1 |=> dout_q == $past(eeprom_dout))
        else $error("serial data bit not captured");
    seed_ones_a: assert property (crc_sel_q |=> crc_seed == CRC_SEED_1)
        else $error("seed not all ones");
    seed_zeros_a: assert property (!crc_sel_q |=> crc_seed == CRC_SEED_0)
        else $error("seed not all zeros");
    pat_en_a: assert property (wr_wk |=> pattern_one_match_en == $past(bus.wdata[WK_PAT1]))
        else $error("pattern one enable not written");

    cov_overflow: cover property (mf_wrap);
    cov_timer_exp: cover property (timer_expired && tm_cont_q);
    cov_ee_read: cover property (eeprom_rd_en && eeprom_cs);
    cov_irq: cover property (irq_tx_done ##1 irq_tx_stopped);
    cov_single_shot: cover property (timer_expired && !tm_cont_q);
endmodule : nacb_csr_bank

// file: nacb_pkg.sv
// Package: constants, register map and carriers for the auxiliary CSR bank
// How it works
// - TX desc-unavail irq needs bit2 and bit16
// - TX stopped irq needs bit1 and bit15
// - TX done irq needs bit0 and bit16
// - Missed counter counts frames dropped without descriptor
// - Reading missed counter returns then clears it
// - Overflow flag bit16 sticks, cleared on read
// - EEPROM read gated by bit14 and select
// - EEPROM write gated by bit13 and select
// - Select bit11 gates the EEPROM read and write enables
// - Bit3 reads EEPROM serial data, resets one
// - Bit2 drives serial data into EEPROM
// - Bit0 drives EEPROM chip select, resets one
// - Timer counts down once per 204 us
// - Bit16 selects continuous timer mode
// - Bit30 picks CRC-16 seed zeros or ones
// - Bit29 enables pattern one wake match
// - Summary enables gate normal and abnormal sources
// - Timer irq needs bit11 and bit15
package nacb_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_EN  = 8'h38;
    localparam logic [7:0] OFS_MISSED  = 8'h40;
    localparam logic [7:0] OFS_EEPROM  = 8'h48;
    localparam logic [7:0] OFS_TIMER   = 8'h58;
    localparam logic [7:0] OFS_WAKEUP  = 8'h68;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IE_TX_DONE   = 0;
    localparam int IE_TX_STOP   = 1;
    localparam int IE_TX_UNAV   = 2;
    localparam int IE_TIMER     = 11;
    localparam int IE_ABNORMAL  = 15;
    localparam int IE_NORMAL    = 16;
    localparam int MF_OVF       = 16;
    localparam int EP_CS        = 0;
    localparam int EP_CLK       = 1;
    localparam int EP_DIN       = 2;
    localparam int EP_DOUT      = 3;
    localparam int EP_SEL       = 11;
    localparam int EP_WR        = 13;
    localparam int EP_RD        = 14;
    localparam int TM_CONT      = 16;
    localparam int WK_PAT1      = 29;
    localparam int WK_CRC       = 30;
    // ------------------------------------------------------------
    // Reset values and seed constants
    // ------------------------------------------------------------
    localparam logic [16:0] IRQ_EN_RST  = 17'h00000;
    localparam logic [3:0]  EEPROM_RST  = 4'hF;
    localparam logic [16:0] TIMER_RST   = 17'h00000;
    localparam logic [1:0]  WAKEUP_RST  = 2'h0;
    localparam logic [15:0] CRC_SEED_0  = 16'h0000;
    localparam logic [15:0] CRC_SEED_1  = 16'hFFFF;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 25;
    localparam int TICK_US      = 204;
    localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } nacb_bus_s;
    typedef struct packed {
        logic clk;
        logic cs;
        logic din;
        logic rd_en;
        logic wr_en;
    } nacb_eeprom_s;
endpackage : nacb_pkg

// file: nacb_tick.sv
// Module: periodic tick generator for the countdown timer
`timescale 1ns/10ps
module nacb_tick
    import nacb_pkg::*;
#(
    parameter int PERIOD = TICK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    output logic      tick_q
);
    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // Refuse periods the 16-bit divider cannot count
    if (PERIOD < 2 || PERIOD > 65535) begin : g_bad_period
        $error("nacb_tick: PERIOD out of range");
    end
    localparam logic [15:0] LAST = 16'(PERIOD - 1);
    logic [15:0] cnt_q;
    // Count cycles, pulse once per period
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end
endmodule : nacb_tick

// file: nacb_eeprom_model.sv
// Serial EEPROM partner: shift register clocked by the software-made serial clock
`timescale 1ns/10ps
module nacb_eeprom_model (
    input  wire logic clk,
    input  wire logic cs,
    input  wire logic din,
    output logic      dout
);
    logic [7:0] sr_q = 8'hFF;
    initial dout = 1'b1;
    // Shift in on each rising serial clock while selected
    always @(posedge clk) begin
        if (cs) begin
            sr_q <= {sr_q[6:0], din};
        end
    end
    // Selected: oldest bit out; released: inverse of the last value
    always @(cs or sr_q) begin
        if (cs) begin
            dout = sr_q[7];
        end else begin
            dout = ~dout;
        end
    end
endmodule : nacb_eeprom_model

// file: tb_nacb_csr_bank.sv
// Testbench for the auxiliary CSR bank
`timescale 1ns/10ps
module tb_nacb_csr_bank;
    import nacb_pkg::*;
    localparam int P = 4;
    logic        clk_sys       = 1'b0;
    logic        rst           = 1'b1;
    logic [7:0]  bus_addr      = 8'h00;
    logic [31:0] bus_wdata     = 32'h0;
    logic        bus_wr        = 1'b0;
    logic        bus_rd        = 1'b0;
    logic        frame_dropped = 1'b0;
    logic [2:0]  ev            = 3'h0;
    logic [31:0] bus_rdata;
    logic [2:0]  irq;
    logic        eeprom_dout;
    logic        eeprom_clk;
    logic        eeprom_cs;
    logic        eeprom_din;
    logic        eeprom_rd_en;
    logic        eeprom_wr_en;
    logic        irq_timer;
    logic        timer_expired;
    logic [15:0] crc_seed;
    logic        pat_en;
    int          n_errors      = 0;
    int          check_count   = 0;
    int          n;
    logic        seen;
    logic [31:0] v;

    nacb_csr_bank #(.TICK_PERIOD(P)) u_nacb_csr_bank (
        .clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .frame_dropped(frame_dropped),
        .ev_tx_done(ev[0]), .ev_tx_stopped(ev[1]), .ev_tx_unavail(ev[2]),
        .eeprom_dout(eeprom_dout), .eeprom_clk(eeprom_clk), .eeprom_cs(eeprom_cs),
        .eeprom_din(eeprom_din), .eeprom_rd_en(eeprom_rd_en), .eeprom_wr_en(eeprom_wr_en),
        .irq_tx_done(irq[0]), .irq_tx_stopped(irq[1]), .irq_tx_unavail(irq[2]),
        .irq_timer(irq_timer), .timer_expired(timer_expired), .crc_seed(crc_seed),
        .pattern_one_match_en(pat_en)
    );
    nacb_eeprom_model u_nacb_eeprom_model (
        .clk(eeprom_clk), .cs(eeprom_cs), .din(eeprom_din), .dout(eeprom_dout)
    );

    // 25 MHz clock
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        check_count++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen_v, exp_v);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_sys);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(bus_rdata & m, e);
    endtask : rdchk

    task automatic idle(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : idle

    // One-cycle event, interrupt expected one cycle later
    task automatic pulse(input int i, input logic e);
        @(posedge clk_sys);
        ev[i] <= 1'b1;
        @(posedge clk_sys);
        ev[i] <= 1'b0;
        #1;
        chk({29'h0, irq}, e ? (32'h1 << i) : 32'h0);
    endtask : pulse

    task automatic drops(input int c);
        @(posedge clk_sys);
        frame_dropped <= 1'b1;
        repeat (c) @(posedge clk_sys);
        frame_dropped <= 1'b0;
    endtask : drops

    // Count cycles to expiry, noting the timer interrupt around it
    task automatic wait_exp(input int lim, output int c, output logic s);
        c = 0;
        s = 1'b0;
        while (c < lim) begin
            @(posedge clk_sys);
            #1;
            c++;
            s = s | (irq_timer === 1'b1);
            if (timer_expired === 1'b1) break;
        end
        repeat (2) begin
            @(posedge clk_sys);
            #1;
            s = s | (irq_timer === 1'b1);
        end
    endtask : wait_exp

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog sized well beyond the overflow run
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        idle(1);
        // Reset values and unmapped space
        chk({27'h0, eeprom_clk, eeprom_cs, eeprom_din, eeprom_rd_en, eeprom_wr_en}, 32'h1C);
        rdchk(OFS_IRQ_EN, 32'h0, 32'hFFFFFFFF);
        rdchk(OFS_EEPROM, 32'hF, 32'hFFFFFFFF);
        rdchk(OFS_TIMER, 32'h0, 32'hFFFFFFFF);
        rdchk(OFS_WAKEUP, 32'h0, 32'hFFFFFFFF);
        wr(8'h10, 32'hFFFFFFFF);
        rdchk(8'h10, 32'h0, 32'hFFFFFFFF);
        $display("reset test done");
        // Each transmit source with the wrong, then the right summary enable
        for (int i = 0; i < 3; i++) begin
            wr(OFS_IRQ_EN, (32'h1 << i) | (32'h1 << ((i == 1) ? IE_NORMAL : IE_ABNORMAL)));
            pulse(i, 1'b0);
            v = (32'h1 << i) | (32'h1 << ((i == 1) ? IE_ABNORMAL : IE_NORMAL));
            wr(OFS_IRQ_EN, v);
            rdchk(OFS_IRQ_EN, v, 32'hFFFFFFFF);
            pulse(i, 1'b1);
        end
        $display("interrupt enable test done");
        // Missed frames: count, clear on read, read-only, overflow
        drops(3);
        rdchk(OFS_MISSED, 32'h3, 32'hFFFFFFFF);
        rdchk(OFS_MISSED, 32'h0, 32'hFFFFFFFF);
        wr(OFS_MISSED, 32'h0000FFFF);
        rdchk(OFS_MISSED, 32'h0, 32'hFFFFFFFF);
        drops(65537);
        rdchk(OFS_MISSED, 32'h00010001, 32'hFFFFFFFF);
        rdchk(OFS_MISSED, 32'h0, 32'hFFFFFFFF);
        $display("missed frame test done");
        // Every combination of select, write and read control
        for (int j = 0; j < 8; j++) begin
            v = (32'(j[2]) << EP_RD) | (32'(j[1]) << EP_WR) | (32'(j[0]) << EP_SEL) | 32'h1;
            wr(OFS_EEPROM, v);
            idle(1);
            chk({27'h0, eeprom_clk, eeprom_cs, eeprom_din, eeprom_rd_en, eeprom_wr_en},
                {27'h0, 3'b010, j[2] & j[0], j[1] & j[0]});
            rdchk(OFS_EEPROM, v, 32'hFFFFFFF7);
        end
        // Software clocks eight zeros into the part, its output then reads back
        for (int k = 0; k < 8; k++) begin
            wr(OFS_EEPROM, 32'h801);
            wr(OFS_EEPROM, 32'h803);
        end
        idle(3);
        rdchk(OFS_EEPROM, 32'h0, 32'h8);
        $display("serial port test done");
        // Single shot timer with its interrupt
        wr(OFS_IRQ_EN, (32'h1 << IE_TIMER) | (32'h1 << IE_ABNORMAL));
        wr(OFS_TIMER, 32'h3);
        wait_exp(40, n, seen);
        chk(32'(n >= 2 * P + 1 && n <= 3 * P), 32'h1);
        chk({31'h0, seen}, 32'h1);
        rdchk(OFS_TIMER, 32'h0, 32'hFFFFFFFF);
        wait_exp(4 * P, n, seen);
        chk(32'(n), 32'(4 * P));
        // Continuous mode reloads and repeats
        wr(OFS_TIMER, 32'h00010002);
        wait_exp(40, n, seen);
        wait_exp(40, n, seen);
        chk(32'(n), 32'(2 * P - 2));
        rdchk(OFS_TIMER, 32'h00010000, 32'hFFFF0000);
        wr(OFS_TIMER, 32'h0);
        wait_exp(4 * P, n, seen);
        chk(32'(n), 32'(4 * P));
        $display("timer test done");
        // Wake-up seed and pattern enable
        for (int k = 0; k < 4; k++) begin
            v = 32'(k) << WK_PAT1;
            wr(OFS_WAKEUP, v);
            idle(1);
            chk({16'h0, crc_seed}, k[1] ? 32'h0000FFFF : 32'h0);
            chk({31'h0, pat_en}, 32'(k[0]));
            rdchk(OFS_WAKEUP, v, 32'hFFFFFFFF);
        end
        $display("wake-up test done");
        tally_and_finish();
    end
endmodule : tb_nacb_csr_bank
